// ---- fpme_top.sv ----
`timescale 1ns/10ps
// Boot mode selection, mode pin termination, option remap and tool link
module fpme_top #(
    parameter int unsigned BAUD_BPS = fpme_pkg::BAUD_MAX_BPS
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic mode_select_pin_i, // Mode pin level
    output logic mode_pin_pull_down_en_o, // Internal pull-down on
    output logic mode_pin_pull_up_en_o, // Internal pull-up on
    input wire logic background_event_control_wr_i, // Write strobe of control register
    input wire logic [7:0] background_event_control_wdata_i, // Write data
    output logic [7:0] background_event_control_o, // Register value
    input wire logic self_prog_i, // Self programming in progress
    input wire logic boot_swap_i, // Boot swap active
    input wire logic [1:0] opt_index_i, // Option byte number 0..3
    output logic [19:0] opt_addr_o, // Fetch address of that byte
    output logic prog_mode_o, // Programming mode latched
    output logic mode_valid_o, // Mode decision taken
    output logic hold_pins_o, // Non-programming pins at reset state
    output logic flash_write_en_o, // Rewriting allowed
    input wire logic tool_serial_pin_i, // Tool pin level
    output logic tool_serial_pin_o, // Tool pin drive level
    output logic tool_serial_pin_oe_o, // High while driving tool pin
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_err_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_start_i,
    output logic tx_busy_o
);
    import fpme_pkg::*;

    fpme_top_state_t s_reg; // Registered state
    fpme_top_state_t s_next; // Next state
    fpme_link_if link (); // Carrier to the serial engine

    // Serial engine; only alive in programming mode
    fpme_uart #(
        .BAUD_BPS(BAUD_BPS)
    ) u_uart (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .link(link)
    );

    assign link.enable = s_reg.prog_mode;
    assign link.rx_line = s_reg.tool_filt;
    assign link.tx_data = tx_data_i;
    assign link.tx_start = tx_start_i & s_reg.prog_mode;

    // Outputs from flops
    assign mode_pin_pull_down_en_o = s_reg.pull_down;
    assign mode_pin_pull_up_en_o = s_reg.pull_up;
    assign background_event_control_o = s_reg.background_event_control;
    assign opt_addr_o = s_reg.opt_addr;
    assign prog_mode_o = s_reg.prog_mode;
    assign mode_valid_o = s_reg.mode_latched;
    assign hold_pins_o = s_reg.hold_pins;
    assign flash_write_en_o = s_reg.flash_wr_en;
    assign tool_serial_pin_o = link.tx_line;
    assign tool_serial_pin_oe_o = link.tx_oe;
    assign rx_data_o = link.rx_data;
    assign rx_valid_o = link.rx_valid;
    assign rx_err_o = link.rx_err;
    assign tx_busy_o = link.tx_busy;

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        // Three-stage synchronisers; a change counts when 2nd and 3rd agree
        s_next.msync = {s_reg.msync[1:0], mode_select_pin_i};
        if (s_reg.msync[1] == s_reg.msync[2]) begin
            s_next.mode_filt = s_reg.msync[2];
        end
        s_next.tsync = {s_reg.tsync[1:0], tool_serial_pin_i};
        if (s_reg.tsync[1] == s_reg.tsync[2]) begin
            s_next.tool_filt = s_reg.tsync[2];
        end
        // Wait for the filter to fill before deciding the mode
        if (!s_reg.mode_latched) begin
            if (s_reg.settle == MODE_SETTLE_CYC) begin
                s_next.mode_latched = 1'b1;
                // Take the filter's new value: the registered copy is
                // still one edge behind the synchroniser at this point
                s_next.prog_mode = s_next.mode_filt;
            end else begin
                s_next.settle = 2'(s_reg.settle + 2'h1);
            end
        end
        // Only the pull-up select bit is writable; the rest read zero
        if (background_event_control_wr_i) begin
            s_next.background_event_control = BACKGROUND_EVENT_CONTROL_RESET;
            s_next.background_event_control[PULLUP_BIT] = background_event_control_wdata_i[PULLUP_BIT];
        end
        // Termination follows software; programming mode keeps pull-down
        s_next.pull_up = s_next.background_event_control[PULLUP_BIT] & ~s_next.prog_mode;
        s_next.pull_down = ~s_next.pull_up;
        // Option bytes come from the alternate block under boot swap during self programming
        if (self_prog_i && boot_swap_i) begin
            s_next.opt_addr = OPT_BASE_SWAP + {18'h00000, opt_index_i};
        end else begin
            s_next.opt_addr = OPT_BASE_NORMAL + {18'h00000, opt_index_i};
        end
        // A pin that stays low against the programmer or the pull-up is
        // taken as tied to ground; a weak board pull-down would also read
        // high here, which is why the pin must be tied hard to block
        if (!s_next.mode_latched) begin
            s_next.flash_wr_en = 1'b0;
        end else if (s_next.prog_mode) begin
            s_next.flash_wr_en = s_next.mode_filt;
        end else begin
            s_next.flash_wr_en = s_reg.mode_filt & s_reg.pull_up;
        end
        s_next.hold_pins = s_next.prog_mode;
    end

    // State register; reset leaves pull-down on and normal mode pending
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '{
                opt_addr: OPT_BASE_NORMAL,
                background_event_control: BACKGROUND_EVENT_CONTROL_RESET,
                pull_down: 1'b1,
                tsync: 3'h7,
                tool_filt: 1'b1,
                default: '0
            };
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : fpme_top

// ---- fpme_pkg.sv ----
// Functional notes
// - Boot swap during self programming moves option bytes to 010C0H
// - Half-duplex single-wire UART on tool pin
// - Bit rate between 115200 and 1000000 bps; BAUD_BPS is not range-checked and the bench runs at 10_000_000
// - Unused pins held at reset state in programming mode
// - Mode pin pulled down during reset
// - Mode pin tied low blocks all rewriting
// - Control register top bit switches termination to pull-up outside programming mode
// - Pin high at release selects programming mode
// - Reset clears control register, top bit pull-up
package fpme_pkg;
    // Core clock rate
    localparam int unsigned CLK_HZ = 100_000_000;
    // Legal serial bit rates
    localparam int unsigned BAUD_MIN_BPS = 115_200;
    localparam int unsigned BAUD_MAX_BPS = 1_000_000;
    // Option byte block bases, byte addresses
    localparam logic [19:0] OPT_BASE_NORMAL = 20'h000C0;
    localparam logic [19:0] OPT_BASE_SWAP = 20'h010C0;
    // Control register reset value and pull-up field position
    localparam logic [7:0] BACKGROUND_EVENT_CONTROL_RESET = 8'h00;
    localparam int unsigned PULLUP_BIT = 7;
    // Cycles after release before the filtered pin is trusted
    localparam logic [1:0] MODE_SETTLE_CYC = 2'h3;
    // Frame layout: start, eight data, stop
    localparam logic [3:0] UART_LAST_DATA = 4'h8;
    localparam logic [3:0] UART_STOP_IDX = 4'h9;

    // Serial engine states, one-hot
    typedef enum logic [2:0] {
        FPME_U_IDLE = 3'b001,
        FPME_U_RX = 3'b010,
        FPME_U_TX = 3'b100
    } fpme_ustate_t;

    // Whole state of the top module
    typedef struct packed {
        logic [2:0] msync;
        logic mode_filt;
        logic [2:0] tsync;
        logic tool_filt;
        logic [1:0] settle;
        logic mode_latched;
        logic prog_mode;
        logic [7:0] background_event_control;
        logic [19:0] opt_addr;
        logic flash_wr_en;
        logic pull_up;
        logic pull_down;
        logic hold_pins;
    } fpme_top_state_t;

    // Whole state of the serial engine
    typedef struct packed {
        fpme_ustate_t st;
        logic [15:0] cnt;
        logic [3:0] bit_idx;
        logic [7:0] shreg;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_err;
        logic tx_line;
        logic tx_oe;
    } fpme_uart_state_t;
endpackage : fpme_pkg

// ---- fpme_link_if.sv ----
`timescale 1ns/10ps
// Carrier between the mode controller and the serial engine
interface fpme_link_if;
    logic enable; // Engine may run (programming mode only)
    logic rx_line; // Filtered tool pin level
    logic tx_line; // Level to drive on the tool pin
    logic tx_oe; // High while the engine drives the pin
    logic [7:0] rx_data; // Last received byte
    logic rx_valid; // One-cycle pulse with rx_data
    logic rx_err; // Stop bit of that byte was low
    logic [7:0] tx_data; // Byte to send
    logic tx_start; // Request to send tx_data
    logic tx_busy; // Engine not idle

    modport ctrl (
        output enable, rx_line, tx_data, tx_start,
        input tx_line, tx_oe, rx_data, rx_valid, rx_err, tx_busy
    );
    modport uart (
        input enable, rx_line, tx_data, tx_start,
        output tx_line, tx_oe, rx_data, rx_valid, rx_err, tx_busy
    );
endinterface : fpme_link_if

// ---- fpme_uart.sv ----
`timescale 1ns/10ps
// Half-duplex single-wire serial engine, 8N1, LSB first
module fpme_uart #(
    parameter int unsigned BAUD_BPS = fpme_pkg::BAUD_MAX_BPS
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    fpme_link_if.uart link
);
    import fpme_pkg::*;

    // Cycles per bit and the offset that puts sampling mid-bit
    localparam logic [15:0] BIT_CYC = 16'(CLK_HZ / BAUD_BPS);
    localparam logic [15:0] HALF_CYC = 16'(CLK_HZ / BAUD_BPS / 2);

    fpme_uart_state_t s_reg; // Registered state
    fpme_uart_state_t s_next; // Next state

    // Outputs come straight from the state flops
    assign link.tx_line = s_reg.tx_line;
    assign link.tx_oe = s_reg.tx_oe;
    assign link.rx_data = s_reg.rx_data;
    assign link.rx_valid = s_reg.rx_valid;
    assign link.rx_err = s_reg.rx_err;
    assign link.tx_busy = ~s_reg.st[0];

    // Next-state logic; one direction at a time on the shared wire
    always_comb begin
        s_next = s_reg;
        s_next.rx_valid = 1'b0;
        unique case (s_reg.st)
            FPME_U_IDLE: begin
                s_next.tx_line = 1'b1;
                s_next.tx_oe = 1'b0;
                s_next.cnt = 16'h0000;
                s_next.bit_idx = 4'h0;
                if (!link.enable) begin
                    // Engine parked outside programming mode
                    s_next.st = FPME_U_IDLE;
                end else if (link.tx_start) begin
                    // Send wins over a start edge seen the same cycle
                    s_next.st = FPME_U_TX;
                    s_next.shreg = link.tx_data;
                    s_next.tx_line = 1'b0;
                    s_next.tx_oe = 1'b1;
                end else if (!link.rx_line) begin
                    s_next.st = FPME_U_RX;
                    s_next.cnt = HALF_CYC;
                end
            end
            FPME_U_RX: begin
                // Own transmissions never reach here, so no echo
                if (s_reg.cnt == BIT_CYC - 16'h0001) begin
                    s_next.cnt = 16'h0000;
                    s_next.bit_idx = 4'(s_reg.bit_idx + 4'h1);
                    if (s_reg.bit_idx == 4'h0) begin
                        // Glitch shorter than half a bit: drop it
                        if (link.rx_line) begin
                            s_next.st = FPME_U_IDLE;
                        end
                    end else if (s_reg.bit_idx <= UART_LAST_DATA) begin
                        s_next.shreg = {link.rx_line, s_reg.shreg[7:1]};
                    end else begin
                        // Mid stop bit: hand the byte over
                        s_next.rx_data = s_reg.shreg;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_err = ~link.rx_line;
                        s_next.st = FPME_U_IDLE;
                    end
                end else begin
                    s_next.cnt = 16'(s_reg.cnt + 16'h0001);
                end
            end
            FPME_U_TX: begin
                if (s_reg.cnt == BIT_CYC - 16'h0001) begin
                    s_next.cnt = 16'h0000;
                    s_next.bit_idx = 4'(s_reg.bit_idx + 4'h1);
                    if (s_reg.bit_idx == UART_STOP_IDX) begin
                        // Release the wire after the stop bit
                        s_next.st = FPME_U_IDLE;
                        s_next.tx_oe = 1'b0;
                        s_next.tx_line = 1'b1;
                    end else if (s_reg.bit_idx < UART_LAST_DATA) begin
                        s_next.tx_line = s_reg.shreg[0];
                        s_next.shreg = {1'b0, s_reg.shreg[7:1]};
                    end else begin
                        s_next.tx_line = 1'b1;
                    end
                end else begin
                    s_next.cnt = 16'(s_reg.cnt + 16'h0001);
                end
            end
            default: begin
                // Illegal code: recover to idle, wire released
                s_next.st = FPME_U_IDLE;
                s_next.tx_oe = 1'b0;
                s_next.tx_line = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '{st: FPME_U_IDLE, tx_line: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : fpme_uart

// ---- fpme_assertions.sv ----
`timescale 1ns/10ps
// Pin-level checker for the boot mode controller
module fpme_chk (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic mode_select_pin_i,
    input wire logic mode_pin_pull_down_en_o,
    input wire logic mode_pin_pull_up_en_o,
    input wire logic background_event_control_wr_i,
    input wire logic [7:0] background_event_control_wdata_i,
    input wire logic [7:0] background_event_control_o,
    input wire logic self_prog_i,
    input wire logic boot_swap_i,
    input wire logic [1:0] opt_index_i,
    input wire logic [19:0] opt_addr_o,
    input wire logic prog_mode_o,
    input wire logic mode_valid_o,
    input wire logic hold_pins_o,
    input wire logic flash_write_en_o,
    input wire logic tool_serial_pin_o,
    input wire logic tool_serial_pin_oe_o,
    input wire logic rx_valid_o,
    input wire logic tx_start_i,
    input wire logic tx_busy_o
);
    import fpme_pkg::*;
    // Single domain, so one clock and one reset for all properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_reset_values: assert property ($rose(resetn_i) |->
        mode_pin_pull_down_en_o && !mode_pin_pull_up_en_o && !prog_mode_o
        && background_event_control_o == 8'h00 && !tool_serial_pin_oe_o)
        else $error("reset state of mode pin termination wrong");
    a_opt_remap: assert property (1'b1 |=> opt_addr_o ==
        ($past(self_prog_i && boot_swap_i) ? OPT_BASE_SWAP : OPT_BASE_NORMAL)
        + {18'h0, $past(opt_index_i)})
        else $error("option byte address wrong");
    a_hold_pins: assert property (hold_pins_o == prog_mode_o)
        else $error("pin hold differs from programming mode");
    a_tied_block: assert property (!mode_select_pin_i [*8] |->
        !flash_write_en_o)
        else $error("rewriting allowed with mode pin low");
    a_ctl_write: assert property (background_event_control_wr_i |=>
        background_event_control_o == {$past(background_event_control_wdata_i[7]), 7'h00})
        else $error("control register write wrong");
    a_pull_select: assert property ($past(mode_valid_o) |->
        mode_pin_pull_up_en_o ==
        (background_event_control_o[7] && !prog_mode_o)
        && mode_pin_pull_down_en_o == !mode_pin_pull_up_en_o)
        else $error("termination does not follow pull-up select");
    a_mode_decide: assert property ($rose(resetn_i) |->
        !mode_valid_o [*4] ##1 mode_valid_o)
        else $error("mode decision out of window");
    a_mode_sample: assert property ($rose(mode_valid_o) |->
        prog_mode_o == $past(mode_select_pin_i, 6))
        else $error("mode does not match pin level");
    a_mode_latched: assert property (mode_valid_o |=>
        mode_valid_o && $stable(prog_mode_o))
        else $error("mode changed before reset");
    a_tx_begin: assert property (tx_start_i && !tx_busy_o &&
        prog_mode_o |=> tool_serial_pin_oe_o && !tool_serial_pin_o)
        else $error("start bit not driven");
    a_normal_quiet: assert property (mode_valid_o && !prog_mode_o |->
        !tool_serial_pin_oe_o)
        else $error("tool pin driven in normal mode");

    c_prog: cover property ($rose(mode_valid_o) && prog_mode_o);
    c_rx: cover property (rx_valid_o);
    c_tx: cover property (tx_start_i && !tx_busy_o && prog_mode_o);
endmodule : fpme_chk

bind fpme_top fpme_chk i_fpme_chk (.*);

// ---- fpme_prog_model.sv ----
`timescale 1ns/10ps
// External programmer as seen on the mode and tool pins
module fpme_prog_model #(
    parameter int BIT_CYC = 10 // Clock cycles per serial bit
) (
    input wire logic clk_i,
    input wire logic tool_line_i, // Resolved tool pin level
    output logic mode_hi_o, // Drives mode pin to supply
    output logic drv_low_o // Pulls tool pin low, else released
);
    initial begin
        mode_hi_o = 1'b0;
        drv_low_o = 1'b0;
    end

    // Strap set before reset release; low means released
    task automatic set_mode(input logic hi);
        mode_hi_o = hi;
    endtask : set_mode

    // One frame, LSB first; a low stop bit is a commanded fault
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_i);
            drv_low_o = ~fr[i];
            repeat (BIT_CYC - 1) @(negedge clk_i);
        end
        @(negedge clk_i);
        drv_low_o = 1'b0;
    endtask : send_byte

    // Samples each bit mid-cell; gives up after forty bit times
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (tool_line_i !== 1'b0 && n < 40 * BIT_CYC) begin
            @(negedge clk_i);
            n++;
        end
        repeat (BIT_CYC / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk_i);
            b[i] = tool_line_i;
        end
        repeat (BIT_CYC) @(negedge clk_i);
        ok = (tool_line_i === 1'b1) && (n < 40 * BIT_CYC);
    endtask : recv_byte
endmodule : fpme_prog_model

// ---- testbench.sv ----
`timescale 1ns/10ps
// Self-checking bench for the boot mode controller
module testbench;
    import fpme_pkg::*;
    localparam int unsigned BAUD = 10_000_000; // Ten cycles a bit
    localparam int BIT_CYC = CLK_HZ / BAUD;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tie_low = 1'b0; // Strap straight to ground
    logic ctl_wr = 1'b0;
    logic [7:0] ctl_wdata = 8'h00;
    logic self_prog = 1'b0;
    logic boot_swap = 1'b0;
    logic [1:0] opt_idx = 2'h0;
    logic [7:0] tx_data = 8'h00;
    logic tx_start = 1'b0;
    wire mode_line, pd_en, pu_en, tool_line, tool_o, tool_oe, mode_hi;
    wire drv_low, prog_mode, mode_valid, hold_pins, wr_en;
    wire rx_valid, rx_err, tx_busy;
    wire [7:0] ctl_o, rx_data;
    wire [19:0] opt_addr;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    // Released pin takes the internal termination; pull-down wins otherwise
    assign mode_line = tie_low ? 1'b0 : (mode_hi | pu_en);
    // Tool pin has a board pull-up
    assign tool_line = (tool_oe ? tool_o : 1'b1) & ~drv_low;

    always #5 sys_clk_i = ~sys_clk_i;

    fpme_top #(.BAUD_BPS(BAUD)) i_fpme_top (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .mode_select_pin_i(mode_line), .mode_pin_pull_down_en_o(pd_en),
        .mode_pin_pull_up_en_o(pu_en), .background_event_control_wr_i(ctl_wr),
        .background_event_control_wdata_i(ctl_wdata), .background_event_control_o(ctl_o),
        .self_prog_i(self_prog), .boot_swap_i(boot_swap),
        .opt_index_i(opt_idx), .opt_addr_o(opt_addr),
        .prog_mode_o(prog_mode), .mode_valid_o(mode_valid),
        .hold_pins_o(hold_pins), .flash_write_en_o(wr_en),
        .tool_serial_pin_i(tool_line), .tool_serial_pin_o(tool_o),
        .tool_serial_pin_oe_o(tool_oe), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .rx_err_o(rx_err), .tx_data_i(tx_data),
        .tx_start_i(tx_start), .tx_busy_o(tx_busy));

    fpme_prog_model #(.BIT_CYC(BIT_CYC)) i_fpme_prog_model (
        .clk_i(sys_clk_i), .tool_line_i(tool_line),
        .mode_hi_o(mode_hi), .drv_low_o(drv_low));

    task automatic check(input string what, input logic [19:0] got,
            input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the few hundred cycles needed
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : tick

    // Reset for five cycles with the strap set, then wait for the decision
    task automatic do_reset(input logic prog);
        int n;
        tick(1);
        resetn_i = 1'b0;
        i_fpme_prog_model.set_mode(prog);
        tick(5);
        check("pull_down_rst", pd_en, 1'b1);
        check("ctl_rst", ctl_o, 8'h00);
        resetn_i = 1'b1;
        n = 0;
        while (mode_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check("mode_valid", mode_valid, 1'b1);
        check("prog_mode", prog_mode, prog);
        check("hold_pins", hold_pins, prog);
    endtask : do_reset

    task automatic wr_ctl(input logic [7:0] d);
        tick(1);
        ctl_wr = 1'b1;
        ctl_wdata = d;
        tick(1);
        ctl_wr = 1'b0;
    endtask : wr_ctl

    task automatic send_tx(input logic [7:0] d);
        tick(1);
        tx_data = d;
        tx_start = 1'b1;
        tick(1);
        tx_start = 1'b0;
    endtask : send_tx

    // Normal boot: pull-up select, strap to ground, refused send
    task automatic t_normal();
        do_reset(1'b0);
        check("wr_en_low", wr_en, 1'b0);
        wr_ctl(8'hFF);
        check("ctl_set", ctl_o, 8'h80);
        check("pull_up", pu_en, 1'b1);
        tick(8);
        check("wr_en_pu", wr_en, 1'b1);
        tie_low = 1'b1;
        tick(8);
        check("wr_en_tied", wr_en, 1'b0);
        tie_low = 1'b0;
        send_tx(8'h55);
        tick(1);
        check("oe_normal", tool_oe, 1'b0);
        wr_ctl(8'h7F);
        check("ctl_clr", ctl_o, 8'h00);
        check("pull_down", pd_en, 1'b1);
    endtask : t_normal

    // All remap and index combinations
    task automatic t_opt();
        for (int k = 0; k < 16; k++) begin
            tick(1);
            {self_prog, boot_swap, opt_idx} = k[3:0];
            tick(1);
            check("opt_addr", opt_addr, (k[3:2] == 2'b11 ? OPT_BASE_SWAP
                : OPT_BASE_NORMAL) + {18'h0, k[1:0]});
        end
    endtask : t_opt

    // Programming boot: response out, good and bad frames in
    task automatic t_prog();
        logic [7:0] b;
        logic ok;
        int n;
        do_reset(1'b1);
        check("wr_en_prog", wr_en, 1'b1);
        send_tx(8'hA5);
        check("tx_busy", tx_busy, 1'b1);
        i_fpme_prog_model.recv_byte(b, ok);
        check("tx_byte", b, 8'hA5);
        check("tx_stop", ok, 1'b1);
        tick(BIT_CYC);
        check("tx_oe_off", tool_oe, 1'b0);
        check("tx_idle", tx_busy, 1'b0);
        for (int f = 0; f < 2; f++) begin
            n = 0;
            fork
                i_fpme_prog_model.send_byte(f ? 8'hC3 : 8'h3C, f == 0);
                while (rx_valid !== 1'b1 && n < 30 * BIT_CYC) begin
                    tick(1);
                    n++;
                end
            join
            check("rx_byte", rx_data, f ? 8'hC3 : 8'h3C);
            check("rx_err", rx_err, f[0]);
        end
        tie_low = 1'b1;
        tick(8);
        check("wr_en_tied_p", wr_en, 1'b0);
        check("mode_held", prog_mode, 1'b1);
        tie_low = 1'b0;
    endtask : t_prog

    initial begin
        t_normal();
        t_opt();
        t_prog();
        tally_and_finish();
    end
endmodule : testbench
